/* rtl/cpu_xfer_pkg.sv */
// Shared types and constants of the data-transfer decode and execute block.
// Assumes one 100 MHz clock; instruction fields arrive already split out of the object code.
package cpu_xfer_pkg;

   // Instruction type codes run 0 to 56, in class order.
   localparam int NUM_TYPES = 57;
   localparam logic [5:0] TYPE_DATA_TRANSFER_OP = 6'h00;
   localparam logic [5:0] TYPE_PERIPH_SYNC = 6'h01;
   localparam logic [5:0] TYPE_STACK = 6'h02;
   localparam logic [5:0] FIRST_ARITH = 6'h03;
   localparam logic [5:0] FIRST_LOGIC = 6'h11;
   localparam logic [5:0] FIRST_SHIFT = 6'h15;
   localparam logic [5:0] FIRST_BIT = 6'h1D;
   localparam logic [5:0] TYPE_COND_BRANCH = 6'h2B;
   localparam logic [5:0] FIRST_SYSTEM = 6'h30;
   localparam logic [5:0] FIRST_BLOCK = 6'h38;
   localparam logic [5:0] TYPE_LIMIT = 6'h39;

   localparam logic [2:0] STACK_REG = 3'h7;
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [7:0] ABS8_PAGE = 8'hFF;
   localparam logic [15:0] WORD_ALIGN_MASK = 16'hFFFE;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   typedef enum logic [2:0] {
      CLS_TRANSFER, CLS_ARITH, CLS_LOGIC, CLS_SHIFT, CLS_BIT, CLS_BRANCH, CLS_SYSTEM, CLS_BLOCK_COPY
   } op_class_t;

   typedef enum logic [2:0] {
      MODE_REG, MODE_IND, MODE_DISP16, MODE_ABS16, MODE_ABS8, MODE_IMM, MODE_PREDEC, MODE_POSTINC
   } mode_t;

   typedef struct packed {
      logic [5:0] type_code;
      logic is_word;
      logic to_mem;
      mode_t mode;
      logic [2:0] ea_reg;
      logic [2:0] data_reg;
      logic [3:0] cond;
      logic [15:0] ext;
   } instr_t;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } flags_t;

   typedef struct packed {
      logic [15:0] addr;
      logic we;
      logic word;
      logic [15:0] wdata;
   } mem_cmd_t;

endpackage

/* rtl/cpu_data_transfer_decode.sv */
// Decode of the whole instruction set into classes, and execution of the data-transfer class.
// Assumes a memory port that answers each held request with a one-cycle ack, never in the request's first cycle.
`timescale 1ns/10ps

// What this block does
// - Recognise 57 instruction types in eight functional classes.
// - General move copies register to register, register to memory, memory to register, or immediate to register.
// - Move supports byte or word with direct, indirect, displacement, absolute, immediate, auto modes.
// - Eight-bit absolute form is byte only; word with it is illegal.
// - Stack store is a word move of a register to pre-decremented stack address.
// - Stack load is a word move from post-incremented stack address into a register.
// - Both peripheral-synchronised byte transfer opcodes are rejected, never executed.
// - Conditional branch carries a condition field choosing which flag test decides it.
// - Word accesses force address bit zero low without any error.
// - Post-increment adds 1 after byte access and 2 after word access.
// - Pre-decrement subtracts 1 before byte access and 2 before word access.
// - Eight-bit absolute address takes all ones as its upper byte.
module cpu_data_transfer_decode (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic instr_valid,
   input wire cpu_xfer_pkg::instr_t instr,
   output logic instr_ready,
   output logic done,
   output logic illegal,
   output cpu_xfer_pkg::op_class_t op_class,
   output logic [3:0] branch_cond,
   output logic branch_taken,
   output cpu_xfer_pkg::flags_t flags,
   output logic mem_req,
   output cpu_xfer_pkg::mem_cmd_t mem_cmd,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   input wire logic [2:0] dbg_sel,
   output logic [15:0] dbg_data
);

   typedef enum logic [0:0] {ST_IDLE, ST_WAIT} state_t;

   typedef struct packed {
      state_t state;
      logic [7:0][15:0] gpr;
      cpu_xfer_pkg::flags_t flags;
      logic ready;
      logic done;
      logic illegal;
      cpu_xfer_pkg::op_class_t op_class;
      logic [3:0] cond;
      logic taken;
      logic mem_req;
      cpu_xfer_pkg::mem_cmd_t cmd;
      logic post_inc;
      logic [2:0] ea_reg;
      logic [2:0] data_reg;
      logic [15:0] dbg;
   } block_state_t;

   block_state_t s_reg;
   block_state_t s_next;

   function automatic cpu_xfer_pkg::op_class_t class_of(input logic [5:0] t);
      if (t < cpu_xfer_pkg::FIRST_ARITH) begin
         class_of = cpu_xfer_pkg::CLS_TRANSFER;
      end else if (t < cpu_xfer_pkg::FIRST_LOGIC) begin
         class_of = cpu_xfer_pkg::CLS_ARITH;
      end else if (t < cpu_xfer_pkg::FIRST_SHIFT) begin
         class_of = cpu_xfer_pkg::CLS_LOGIC;
      end else if (t < cpu_xfer_pkg::FIRST_BIT) begin
         class_of = cpu_xfer_pkg::CLS_SHIFT;
      end else if (t < cpu_xfer_pkg::TYPE_COND_BRANCH) begin
         class_of = cpu_xfer_pkg::CLS_BIT;
      end else if (t < cpu_xfer_pkg::FIRST_SYSTEM) begin
         class_of = cpu_xfer_pkg::CLS_BRANCH;
      end else if (t < cpu_xfer_pkg::FIRST_BLOCK) begin
         class_of = cpu_xfer_pkg::CLS_SYSTEM;
      end else begin
         class_of = cpu_xfer_pkg::CLS_BLOCK_COPY;
      end
   endfunction

   // Standard sixteen flag tests; code 0 is always, code 1 never.
   function automatic logic cond_true(input logic [3:0] cc, input cpu_xfer_pkg::flags_t f);
      logic base;
      case (cc[3:1])
         3'h0: base = 1'b1;
         3'h1: base = !(f.c | f.z);
         3'h2: base = !f.c;
         3'h3: base = !f.z;
         3'h4: base = !f.v;
         3'h5: base = !f.n;
         3'h6: base = !(f.n ^ f.v);
         default: base = !(f.z | (f.n ^ f.v));
      endcase
      cond_true = cc[0] ? !base : base;
   endfunction

   function automatic cpu_xfer_pkg::flags_t move_flags(input cpu_xfer_pkg::flags_t f, input logic [15:0] val,
                                                       input logic word);
      move_flags = f;
      move_flags.n = word ? val[15] : val[7];
      move_flags.z = word ? (val == 16'h0000) : (val[7:0] == cpu_xfer_pkg::ZERO_BYTE);
      move_flags.v = 1'b0;
   endfunction

   function automatic logic [15:0] step_of(input logic word);
      step_of = word ? cpu_xfer_pkg::WORD_STEP : cpu_xfer_pkg::BYTE_STEP;
   endfunction

   always_comb begin
      cpu_xfer_pkg::instr_t ins;
      logic [15:0] base;
      logic [15:0] ea;
      logic [15:0] val;
      logic accept;
      logic bad;
      ins = instr;
      base = 16'h0000;
      ea = 16'h0000;
      val = 16'h0000;
      accept = 1'b0;
      bad = 1'b0;
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.illegal = 1'b0;
      s_next.dbg = s_reg.gpr[dbg_sel];
      case (s_reg.state)
         ST_IDLE: begin
            accept = instr_valid;
            if (accept && (ins.type_code == cpu_xfer_pkg::TYPE_STACK)) begin
               ins.is_word = 1'b1;
               ins.ea_reg = cpu_xfer_pkg::STACK_REG;
               ins.mode = ins.to_mem ? cpu_xfer_pkg::MODE_PREDEC : cpu_xfer_pkg::MODE_POSTINC;
               ins.type_code = cpu_xfer_pkg::TYPE_DATA_TRANSFER_OP;
            end
            if (accept) begin
               s_next.op_class = class_of(ins.type_code);
               s_next.cond = ins.cond;
               s_next.taken = 1'b0;
               bad = (ins.type_code >= cpu_xfer_pkg::TYPE_LIMIT)
                  || (ins.type_code == cpu_xfer_pkg::TYPE_PERIPH_SYNC);
               if (ins.type_code == cpu_xfer_pkg::TYPE_DATA_TRANSFER_OP) begin
                  bad = bad || (ins.is_word && ins.mode == cpu_xfer_pkg::MODE_ABS8)
                     || (ins.to_mem && (ins.mode == cpu_xfer_pkg::MODE_IMM || ins.mode == cpu_xfer_pkg::MODE_POSTINC))
                     || (!ins.to_mem && ins.mode == cpu_xfer_pkg::MODE_PREDEC);
               end
               base = s_reg.gpr[ins.ea_reg];
               case (ins.mode)
                  cpu_xfer_pkg::MODE_DISP16: ea = base + ins.ext;
                  cpu_xfer_pkg::MODE_ABS16: ea = ins.ext;
                  cpu_xfer_pkg::MODE_ABS8: ea = {cpu_xfer_pkg::ABS8_PAGE, ins.ext[7:0]};
                  cpu_xfer_pkg::MODE_PREDEC: ea = base - step_of(ins.is_word);
                  default: ea = base;
               endcase
               if (ins.is_word) begin
                  ea = ea & cpu_xfer_pkg::WORD_ALIGN_MASK;
               end
               if (bad) begin
                  s_next.illegal = 1'b1;
               end else if (ins.type_code != cpu_xfer_pkg::TYPE_DATA_TRANSFER_OP) begin
                  // Other classes are only classified here, apart from the conditional branch's flag test; their execution lives elsewhere.
                  s_next.done = 1'b1;
                  if (ins.type_code == cpu_xfer_pkg::TYPE_COND_BRANCH) begin
                     s_next.taken = cond_true(ins.cond, s_reg.flags);
                  end
               end else if (ins.mode == cpu_xfer_pkg::MODE_REG || ins.mode == cpu_xfer_pkg::MODE_IMM) begin
                  val = (ins.mode == cpu_xfer_pkg::MODE_IMM) ? ins.ext : base;
                  if (ins.is_word) begin
                     s_next.gpr[ins.data_reg] = val;
                  end else begin
                     s_next.gpr[ins.data_reg][7:0] = val[7:0];
                  end
                  s_next.flags = move_flags(s_reg.flags, val, ins.is_word);
                  s_next.done = 1'b1;
               end else begin
                  if (ins.mode == cpu_xfer_pkg::MODE_PREDEC) begin
                     s_next.gpr[ins.ea_reg] = base - step_of(ins.is_word);
                  end
                  val = s_reg.gpr[ins.data_reg];
                  s_next.cmd.addr = ea;
                  s_next.cmd.we = ins.to_mem;
                  s_next.cmd.word = ins.is_word;
                  s_next.cmd.wdata = ins.is_word ? val : {cpu_xfer_pkg::ZERO_BYTE, val[7:0]};
                  s_next.post_inc = (ins.mode == cpu_xfer_pkg::MODE_POSTINC);
                  s_next.ea_reg = ins.ea_reg;
                  s_next.data_reg = ins.data_reg;
                  s_next.mem_req = 1'b1;
                  s_next.ready = 1'b0;
                  s_next.state = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (mem_ack) begin
               val = s_reg.cmd.we ? s_reg.cmd.wdata : mem_rdata;
               if (!s_reg.cmd.we) begin
                  if (s_reg.cmd.word) begin
                     s_next.gpr[s_reg.data_reg] = val;
                  end else begin
                     s_next.gpr[s_reg.data_reg][7:0] = val[7:0];
                  end
               end
               if (s_reg.post_inc) begin
                  s_next.gpr[s_reg.ea_reg] = s_reg.gpr[s_reg.ea_reg] + step_of(s_reg.cmd.word);
               end
               s_next.flags = move_flags(s_reg.flags, val, s_reg.cmd.word);
               s_next.mem_req = 1'b0;
               s_next.ready = 1'b1;
               s_next.done = 1'b1;
               s_next.state = ST_IDLE;
            end
         end
         default: s_next.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_reg <= '0;
         s_reg.ready <= 1'b1;
         s_reg.state <= ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign instr_ready = s_reg.ready;
   assign done = s_reg.done;
   assign illegal = s_reg.illegal;
   assign op_class = s_reg.op_class;
   assign branch_cond = s_reg.cond;
   assign branch_taken = s_reg.taken;
   assign flags = s_reg.flags;
   assign mem_req = s_reg.mem_req;
   assign mem_cmd = s_reg.cmd;
   assign dbg_data = s_reg.dbg;

   // Checks. Helper values sampled through $past.
   logic take;
   logic [15:0] sp_val;
   logic [15:0] ea_val;
   logic is_move;
   assign take = instr_valid && instr_ready;
   assign sp_val = s_reg.gpr[cpu_xfer_pkg::STACK_REG];
   assign ea_val = s_reg.gpr[instr.ea_reg];
   assign is_move = instr.type_code == cpu_xfer_pkg::TYPE_DATA_TRANSFER_OP;

   a_type_limit: assert property (@(posedge clk_sys) disable iff (srst)
      take && instr.type_code >= cpu_xfer_pkg::TYPE_LIMIT |=> illegal && !done) else $error("out-of-range type accepted");
   a_imm_load: assert property (@(posedge clk_sys) disable iff (srst)
      take && is_move && instr.mode == cpu_xfer_pkg::MODE_IMM && instr.is_word && !instr.to_mem
      |=> done && s_reg.gpr[$past(instr.data_reg)] == $past(instr.ext)) else $error("immediate not loaded");
   a_abs8_word: assert property (@(posedge clk_sys) disable iff (srst)
      take && is_move && instr.is_word && instr.mode == cpu_xfer_pkg::MODE_ABS8 |=> illegal && !mem_req)
      else $error("word absolute-8 not refused");
   a_abs8_page: assert property (@(posedge clk_sys) disable iff (srst)
      take && is_move && !instr.is_word && instr.mode == cpu_xfer_pkg::MODE_ABS8
      |=> mem_req && mem_cmd.addr[15:8] == cpu_xfer_pkg::ABS8_PAGE) else $error("absolute-8 page wrong");
   a_periph_refused: assert property (@(posedge clk_sys) disable iff (srst)
      take && instr.type_code == cpu_xfer_pkg::TYPE_PERIPH_SYNC |=> illegal && !mem_req && !done)
      else $error("peripheral transfer executed");
   a_push_store: assert property (@(posedge clk_sys) disable iff (srst)
      take && instr.type_code == cpu_xfer_pkg::TYPE_STACK && instr.to_mem
      |=> mem_req && mem_cmd.we && mem_cmd.word && sp_val == $past(sp_val) - cpu_xfer_pkg::WORD_STEP)
      else $error("stack store wrong");
   a_pop_load: assert property (@(posedge clk_sys) disable iff (srst)
      take && instr.type_code == cpu_xfer_pkg::TYPE_STACK && !instr.to_mem
      |=> mem_req && !mem_cmd.we && mem_cmd.word && mem_cmd.addr == ($past(sp_val) & cpu_xfer_pkg::WORD_ALIGN_MASK))
      else $error("stack load wrong");
   a_predec_byte: assert property (@(posedge clk_sys) disable iff (srst)
      take && is_move && !instr.is_word && instr.to_mem && instr.mode == cpu_xfer_pkg::MODE_PREDEC
      |=> mem_cmd.addr == $past(ea_val) - cpu_xfer_pkg::BYTE_STEP) else $error("byte pre-decrement wrong");
   a_word_align: assert property (@(posedge clk_sys) disable iff (srst)
      mem_req && mem_cmd.word |-> !mem_cmd.addr[0]) else $error("odd word address issued");
   a_postinc_step: assert property (@(posedge clk_sys) disable iff (srst)
      mem_req && mem_ack && s_reg.post_inc && s_reg.ea_reg == cpu_xfer_pkg::STACK_REG && s_reg.data_reg != s_reg.ea_reg
      |=> sp_val == $past(sp_val) + step_of($past(mem_cmd.word))) else $error("post-increment step wrong");
   a_move_flags: assert property (@(posedge clk_sys) disable iff (srst)
      done && op_class == cpu_xfer_pkg::CLS_TRANSFER |-> !flags.v && flags.c == $past(flags.c))
      else $error("move flags wrong");
   a_branch_cond: assert property (@(posedge clk_sys) disable iff (srst)
      take && instr.type_code == cpu_xfer_pkg::TYPE_COND_BRANCH && instr.cond == 4'h1 |=> done && !branch_taken)
      else $error("never-branch taken");

   c_push: cover property (@(posedge clk_sys) take && instr.type_code == cpu_xfer_pkg::TYPE_STACK && instr.to_mem);
   c_pop_done: cover property (@(posedge clk_sys) mem_req && mem_ack && s_reg.post_inc ##1 done);
   c_illegal: cover property (@(posedge clk_sys) illegal);
   c_branch_taken: cover property (@(posedge clk_sys) done && branch_taken);

endmodule

/* tb/cpu_data_transfer_decode_tb.sv */
// Self-checking bench for the data-transfer decode and execute block.
// Assumes the block's own assertions guard its ports; this bench plays both the instruction source and memory.
`timescale 1ns/10ps
module cpu_data_transfer_decode_tb;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic instr_valid = 1'b0;
   cpu_xfer_pkg::instr_t instr = '0;
   logic instr_ready, done, illegal, branch_taken, mem_req;
   cpu_xfer_pkg::op_class_t op_class;
   logic [3:0] branch_cond;
   cpu_xfer_pkg::flags_t flags;
   cpu_xfer_pkg::mem_cmd_t mem_cmd, cmd_seen;
   logic mem_ack = 1'b0;
   logic [15:0] mem_rdata = 16'h0000;
   logic [2:0] dbg_sel = 3'h0;
   logic [15:0] dbg_data;
   logic saw_done, saw_ill, req_seen, rdy_in_req;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;

   cpu_data_transfer_decode cpu_data_transfer_decode_inst (.clk_sys(clk_sys), .srst(srst),
      .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .done(done), .illegal(illegal),
      .op_class(op_class), .branch_cond(branch_cond), .branch_taken(branch_taken), .flags(flags),
      .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dbg_sel(dbg_sel),
      .dbg_data(dbg_data));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic summarize();
      if (bad_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // The run takes well under a thousand cycles; the ceiling leaves generous room.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic cpu_xfer_pkg::instr_t mk(input logic [5:0] t, input logic w, input logic m,
         input cpu_xfer_pkg::mode_t md, input logic [2:0] ea, input logic [2:0] dr, input logic [15:0] x);
      mk = '{t, w, m, md, ea, dr, 4'h0, x};
   endfunction

   // Offers one instruction and acts as memory; lat is the extra wait before the ack, at least one.
   // Released read data shows the inverse of the last value so stale data never looks valid.
   task automatic run_op(input cpu_xfer_pkg::instr_t op, input logic [15:0] rd, input int lat);
      int k;
      int wait_n;
      saw_done = 1'b0;
      saw_ill = 1'b0;
      req_seen = 1'b0;
      wait_n = 0;
      k = 0;
      // One idle edge first, so a back-to-back call never re-raises valid in the step that lowered it.
      @(negedge clk_sys);
      while (instr_ready !== 1'b1 && k < 50) begin
         @(negedge clk_sys);
         k++;
      end
      instr = op;
      instr_valid = 1'b1;
      @(negedge clk_sys);
      instr_valid = 1'b0;
      for (k = 0; k < 40; k++) begin
         if (done === 1'b1) saw_done = 1'b1;
         if (illegal === 1'b1) saw_ill = 1'b1;
         if (mem_ack) begin
            mem_ack = 1'b0;
            mem_rdata = ~rd;
         end else if (mem_req === 1'b1) begin
            if (!req_seen) begin
               req_seen = 1'b1;
               cmd_seen = mem_cmd;
               rdy_in_req = instr_ready;
            end
            wait_n++;
            if (wait_n > lat) begin
               chk({15'h0000, mem_cmd !== cmd_seen}, 16'h0000, "command held");
               mem_ack = 1'b1;
               mem_rdata = rd;
            end
         end
         if (saw_done || saw_ill) break;
         @(negedge clk_sys);
      end
   endtask

   task automatic reg_chk(input logic [2:0] sel, input logic [15:0] exp);
      @(negedge clk_sys);
      dbg_sel = sel;
      @(negedge clk_sys);
      chk(dbg_data, exp, "register");
   endtask

   task automatic s_reg_moves();
      run_op(mk(6'h00, 1'b1, 1'b0, cpu_xfer_pkg::MODE_IMM, 3'h0, 3'h0, 16'h8001), 16'h0000, 1);
      chk({15'h0000, saw_done}, 16'h0001, "imm done");
      chk({12'h000, flags}, 16'h0008, "imm flags");
      reg_chk(3'h0, 16'h8001);
      run_op(mk(6'h00, 1'b1, 1'b0, cpu_xfer_pkg::MODE_IMM, 3'h7, 3'h7, 16'h1001), 16'h0000, 1);
      run_op(mk(6'h00, 1'b0, 1'b0, cpu_xfer_pkg::MODE_REG, 3'h0, 3'h1, 16'h0000), 16'h0000, 1);
      chk({9'h000, op_class, flags}, 16'h0000, "reg class and flags");
      reg_chk(3'h1, 16'h0001);
   endtask

   task automatic s_refused();
      cpu_xfer_pkg::instr_t bad_ops [6];
      bad_ops[0] = mk(6'h01, 1'b0, 1'b1, cpu_xfer_pkg::MODE_IND, 3'h0, 3'h1, 16'h0000);
      bad_ops[1] = mk(6'h01, 1'b0, 1'b0, cpu_xfer_pkg::MODE_IND, 3'h0, 3'h0, 16'h0000);
      bad_ops[2] = mk(6'h39, 1'b0, 1'b0, cpu_xfer_pkg::MODE_REG, 3'h0, 3'h0, 16'h0000);
      bad_ops[3] = mk(6'h00, 1'b1, 1'b0, cpu_xfer_pkg::MODE_ABS8, 3'h0, 3'h0, 16'h0010);
      bad_ops[4] = mk(6'h00, 1'b1, 1'b1, cpu_xfer_pkg::MODE_IMM, 3'h0, 3'h0, 16'h1234);
      bad_ops[5] = mk(6'h00, 1'b1, 1'b0, cpu_xfer_pkg::MODE_PREDEC, 3'h1, 3'h0, 16'h0000);
      foreach (bad_ops[i]) begin
         run_op(bad_ops[i], 16'hFFFF, 1);
         chk({14'h0000, saw_ill, saw_done | req_seen}, 16'h0002, "refusal");
      end
      reg_chk(3'h0, 16'h8001);
      reg_chk(3'h1, 16'h0001);
   endtask

   task automatic s_mem_moves();
      run_op(mk(6'h00, 1'b0, 1'b1, cpu_xfer_pkg::MODE_ABS8, 3'h0, 3'h1, 16'h0034), 16'h0000, 3);
      chk(cmd_seen.addr, 16'hFF34, "abs8 address");
      chk({12'h000, cmd_seen.we, cmd_seen.word, rdy_in_req, saw_done}, 16'h0009, "abs8 store");
      chk(cmd_seen.wdata, 16'h0001, "abs8 data");
      run_op(mk(6'h02, 1'b1, 1'b1, cpu_xfer_pkg::MODE_PREDEC, 3'h7, 3'h0, 16'h0000), 16'h0000, 1);
      chk(cmd_seen.addr, 16'h0FFE, "push address");
      chk({13'h0000, cmd_seen.we, cmd_seen.word, saw_done}, 16'h0007, "push kind");
      chk(cmd_seen.wdata, 16'h8001, "push data");
      reg_chk(3'h7, 16'h0FFF);
      run_op(mk(6'h02, 1'b1, 1'b0, cpu_xfer_pkg::MODE_POSTINC, 3'h7, 3'h2, 16'h0000), 16'h0000, 2);
      chk(cmd_seen.addr, 16'h0FFE, "pop address");
      chk({13'h0000, cmd_seen.we, cmd_seen.word, saw_done}, 16'h0003, "pop kind");
      chk({12'h000, flags}, 16'h0004, "pop flags");
      reg_chk(3'h7, 16'h1001);
      reg_chk(3'h2, 16'h0000);
      run_op(mk(6'h00, 1'b0, 1'b0, cpu_xfer_pkg::MODE_POSTINC, 3'h3, 3'h4, 16'h0000), 16'h5A80, 1);
      chk({12'h000, flags}, 16'h0008, "byte load flags");
      reg_chk(3'h4, 16'h0080);
      reg_chk(3'h3, 16'h0001);
      run_op(mk(6'h00, 1'b0, 1'b1, cpu_xfer_pkg::MODE_PREDEC, 3'h3, 3'h4, 16'h0000), 16'h0000, 1);
      chk(cmd_seen.addr, 16'h0000, "byte pre-decrement address");
      chk(cmd_seen.wdata, 16'h0080, "byte store data");
      reg_chk(3'h3, 16'h0000);
   endtask

   // Class sizes in order: transfer, arithmetic, logic, shift, bit, branch, system, block copy.
   task automatic s_classify();
      int sizes [8] = '{3, 14, 4, 8, 14, 5, 8, 1};
      int cls;
      int lim;
      for (int t = 3; t < 57; t++) begin
         cls = 0;
         lim = sizes[0];
         while (t >= lim) begin
            cls++;
            lim += sizes[cls];
         end
         run_op(mk(6'(t), 1'b0, 1'b0, cpu_xfer_pkg::MODE_REG, 3'h0, 3'h0, 16'h0000), 16'h0000, 1);
         chk({12'h000, op_class, saw_done}, 16'(cls * 2 + 1), "class");
      end
   endtask

   // Negative flag is set here, so the plain test and the inverted test must disagree.
   task automatic s_branch();
      logic [3:0] conds [4] = '{4'h0, 4'h1, 4'hA, 4'hB};
      logic exp_taken [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      cpu_xfer_pkg::instr_t op;
      foreach (conds[i]) begin
         op = mk(6'h2B, 1'b0, 1'b0, cpu_xfer_pkg::MODE_REG, 3'h0, 3'h0, 16'h0000);
         op.cond = conds[i];
         run_op(op, 16'h0000, 1);
         chk({11'h000, branch_cond, branch_taken}, {11'h000, conds[i], exp_taken[i]}, "branch");
      end
   endtask

   initial begin
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      s_reg_moves();
      s_refused();
      s_mem_moves();
      s_classify();
      s_branch();
      summarize();
   end
endmodule
